// *** common/sasc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SASC_REGS_SVH
`define SASC_REGS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define SASC_OFF_CTRL1      12'h000
`define SASC_OFF_CTRL2      12'h004
`define SASC_OFF_CLKT       12'h008
`define SASC_OFF_DEPTH      12'h00C
// ----------------------------------------
// Control one fields
// ----------------------------------------
`define SASC_C1_ON          15
`define SASC_C1_RES         10
`define SASC_C1_TRIG_LO     5
`define SASC_C1_SIM         3
`define SASC_C1_AUTO_SAMPLE_START        2
`define SASC_C1_SAMPLE_ENABLE_BIT        1
`define SASC_C1_DONE        0
`define SASC_C1_WMASK       16'h84EE
// ----------------------------------------
// Control two fields
// ----------------------------------------
`define SASC_C2_REF_LO      13
`define SASC_C2_SCAN        10
`define SASC_C2_CHN_LO      8
`define SASC_C2_BUFFER_FILL_STATUS        7
`define SASC_C2_RATE_LO     2
`define SASC_C2_BUFFER_FILL_MODE        1
`define SASC_C2_ALT         0
`define SASC_C2_WMASK       16'hE73F
// ----------------------------------------
// Clock timing and depth
// ----------------------------------------
`define SASC_C3_RC          15
`define SASC_C3_WMASK       16'h9FFF
`define SASC_C4_WMASK       16'h0007
`define SASC_RESET_VAL      16'h0000
`define SASC_TRIG_SOFT      3'h0
`define SASC_TRIG_AUTO      3'h7
`define SASC_DIV_MAX        8'h3F
`define SASC_RC_PERIOD_NS   250
`define SASC_CLK_NS         50
`define SASC_RC_CYC         ((`SASC_RC_PERIOD_NS + `SASC_CLK_NS - 1) / `SASC_CLK_NS)
`endif

// *** common/sasc_pkg.sv ***
// Types for the converter sequence controller
package sasc_pkg;
    typedef enum logic [3:0] {
        SASC_IDLE   = 4'b0001,
        SASC_SAMPLE = 4'b0010,
        SASC_CONV   = 4'b0100,
        SASC_GAP    = 4'b1000
    } sasc_state_t;

    typedef struct packed {
        logic       sampling;
        logic [3:0] channels;
        logic       simultaneous;
        logic       use_b;
        logic       scan;
        logic [1:0] vref_sel;
        logic       start_conv;
    } sasc_analog_t;
endpackage : sasc_pkg

// *** hdl/sasc_ctrl.sv ***
// Sample and conversion sequence controller with APB registers
// Behaviour
// - Simultaneous bit samples selected channels together
// - Simultaneous bit reads zero in 12-bit
// - Auto-start resamples after conversion, sets enable
// - Sample-enable high means sampling, low holding
// - Trigger zero: software ends sampling; else hardware
// - Done set at completion, cleared at start
// - Software clears done; no effect on conversion
// - Reference field selects high and low references
// - Scan bit steps channel zero during A
// - Channel count selects one, two, four channels
// - Channel count reads zero in 12-bit
// - Fill status shows half being filled
// - Increment after every field plus one operations
// - Fill mode alternates halves per interrupt
// - Alternate bit swaps A and B selections
// - Clock source picks RC or system clock
// - Auto sample time counts conversion clocks
// - Divider sets conversion clock, capped 64
// - Divider ignored when RC clock chosen
// - Depth field reserves two power words
// - Resolution bit picks 12-bit one channel
// - Internal counter ends sampling automatically
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "sasc_regs.svh"

module sasc_ctrl #(
    parameter int CONV_TAD = 12
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ext_trigger,
    output sasc_pkg::sasc_analog_t     analog_ctl,
    output logic                       dma_increment,
    output logic      [7:0]            dma_buffer_words
);
    // ----------------------------------------
    // Registers and bus decode
    // ----------------------------------------
    logic [15:0] converter_control_one;
    logic [15:0] converter_control_two;
    logic [15:0] converter_clock_timing;
    logic [15:0] dma_buffer_depth;
    logic        sample_enable_bit;
    logic        conv_done;
    logic        buffer_fill_status;
    sasc_pkg::sasc_state_t state;
    sasc_pkg::sasc_state_t next_state;

    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit1     = paddr == `SASC_OFF_CTRL1;
    wire hit2     = paddr == `SASC_OFF_CTRL2;
    wire hit3     = paddr == `SASC_OFF_CLKT;
    wire hit4     = paddr == `SASC_OFF_DEPTH;
    wire mapped   = hit1 | hit2 | hit3 | hit4;
    wire wr1      = wr & hit1;

    wire module_on_bit        = converter_control_one[`SASC_C1_ON];
    wire resolution_mode_sel  = converter_control_one[`SASC_C1_RES];
    wire [2:0] conversion_trigger_source = converter_control_one[`SASC_C1_TRIG_LO +: 3];
    wire auto_sample_start    = converter_control_one[`SASC_C1_AUTO_SAMPLE_START];
    // Unimplemented in 12-bit mode
    wire simultaneous_sample_sel = converter_control_one[`SASC_C1_SIM]
                                   & ~resolution_mode_sel;
    wire [1:0] channel_count_sel = resolution_mode_sel ? 2'h0 :
                                   converter_control_two[`SASC_C2_CHN_LO +: 2];
    wire [2:0] reference_config  = converter_control_two[`SASC_C2_REF_LO +: 3];
    wire scan_enable_bit      = converter_control_two[`SASC_C2_SCAN];
    wire [3:0] increment_rate = converter_control_two[`SASC_C2_RATE_LO +: 4];
    wire buffer_fill_mode     = converter_control_two[`SASC_C2_BUFFER_FILL_MODE];
    wire alternate_input_mode = converter_control_two[`SASC_C2_ALT];
    wire conv_clock_source    = converter_clock_timing[`SASC_C3_RC];
    wire [4:0] auto_sample_time  = converter_clock_timing[12:8];
    wire [7:0] conv_clock_divider = converter_clock_timing[7:0];
    wire [2:0] buffer_depth_sel  = dma_buffer_depth[2:0];

    wire [15:0] rd1 = {converter_control_one[15:4], simultaneous_sample_sel,
                       auto_sample_start, sample_enable_bit, conv_done};
    wire [15:0] rd2 = {converter_control_two[15:10], channel_count_sel,
                       buffer_fill_status, converter_control_two[6:0]};
    wire [15:0] rdv = hit1 ? rd1 : hit2 ? rd2 : hit3 ? converter_clock_timing :
                      hit4 ? dma_buffer_depth : 16'h0000;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_control_one  <= `SASC_RESET_VAL;
            converter_control_two  <= `SASC_RESET_VAL;
            converter_clock_timing <= `SASC_RESET_VAL;
            dma_buffer_depth       <= `SASC_RESET_VAL;
            prdata                 <= 32'h0000_0000;
        end else begin
            if (wr1)
                converter_control_one <= pwdata[15:0] & `SASC_C1_WMASK;
            if (wr & hit2)
                converter_control_two <= pwdata[15:0] & `SASC_C2_WMASK;
            if (wr & hit3)
                converter_clock_timing <= pwdata[15:0] & `SASC_C3_WMASK;
            if (wr & hit4)
                dma_buffer_depth <= pwdata[15:0] & `SASC_C4_WMASK;
            if (psel & ~penable & ~pwrite)
                prdata <= {16'h0000, rdv};
        end
    end

    // ----------------------------------------
    // Conversion clock enable
    // ----------------------------------------
    // Reserved divider codes saturate at 64 cycles
    wire [7:0] div_lim = (conv_clock_divider > `SASC_DIV_MAX) ? `SASC_DIV_MAX
                         : conv_clock_divider;
    wire [7:0] tad_lim = conv_clock_source ? 8'(`SASC_RC_CYC - 1) : div_lim;
    logic [7:0] tad_cnt;
    wire tad_tick = module_on_bit & (tad_cnt >= tad_lim);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tad_cnt <= 8'h00;
        else if (tad_tick | ~module_on_bit)
            tad_cnt <= 8'h00;
        else
            tad_cnt <= tad_cnt + 8'h01;
    end

    // ----------------------------------------
    // External trigger sync
    // ----------------------------------------
    // Three stages; edge counts once stages two and three agree
    logic [2:0] trg_sync;
    logic       trg_level;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_sync  <= 3'h0;
            trg_level <= 1'b0;
        end else begin
            trg_sync <= {trg_sync[1:0], ext_trigger};
            if (trg_sync[2] == trg_sync[1])
                trg_level <= trg_sync[2];
        end
    end
    wire trg_rise = (trg_sync[2] == trg_sync[1]) & trg_sync[2] & ~trg_level;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [4:0] sample_enable_bit_cnt;
    logic [4:0] conv_cnt;
    logic [3:0] op_cnt;
    logic       use_b;
    wire soft_trig = conversion_trigger_source == `SASC_TRIG_SOFT;
    wire auto_trig = conversion_trigger_source == `SASC_TRIG_AUTO;
    wire sw_set    = wr1 & pwdata[`SASC_C1_SAMPLE_ENABLE_BIT] & ~auto_sample_start;
    wire sw_clr    = wr1 & ~pwdata[`SASC_C1_SAMPLE_ENABLE_BIT] & soft_trig;
    // Compare the count plus one, so a field of N gives N whole periods, not N + 1
    // Limitation: a field of zero still samples until the first period boundary
    wire [5:0] sample_enable_bit_next = {1'b0, sample_enable_bit_cnt} + 6'h01;
    wire auto_end  = auto_trig & tad_tick
                     & (sample_enable_bit_next >= {1'b0, auto_sample_time});
    wire hw_end    = auto_end | (~soft_trig & ~auto_trig & trg_rise);
    wire end_sample_enable_bit  = (state == sasc_pkg::SASC_SAMPLE) & (sw_clr | hw_end);
    wire conv_fin  = (state == sasc_pkg::SASC_CONV) & tad_tick
                     & (conv_cnt == 5'(CONV_TAD - 1));
    wire op_wrap   = conv_fin & (op_cnt == increment_rate);

    always_comb begin
        next_state = state;
        unique case (state)
            sasc_pkg::SASC_IDLE:
                if (sw_set | auto_sample_start)
                    next_state = sasc_pkg::SASC_SAMPLE;
            sasc_pkg::SASC_SAMPLE:
                if (end_sample_enable_bit)
                    next_state = sasc_pkg::SASC_CONV;
            sasc_pkg::SASC_CONV:
                if (conv_fin)
                    next_state = auto_sample_start ? sasc_pkg::SASC_SAMPLE
                                 : sasc_pkg::SASC_IDLE;
            default:
                next_state = sasc_pkg::SASC_IDLE;
        endcase
        if (!module_on_bit)
            next_state = sasc_pkg::SASC_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= sasc_pkg::SASC_IDLE;
            sample_enable_bit_cnt           <= 5'h00;
            conv_cnt           <= 5'h00;
            op_cnt             <= 4'h0;
            use_b              <= 1'b0;
            buffer_fill_status <= 1'b0;
        end else begin
            state <= next_state;
            if (state != sasc_pkg::SASC_SAMPLE || end_sample_enable_bit)
                sample_enable_bit_cnt <= 5'h00;
            else if (tad_tick && sample_enable_bit_cnt != 5'h1F)
                sample_enable_bit_cnt <= sample_enable_bit_cnt + 5'h01;
            if (state != sasc_pkg::SASC_CONV)
                conv_cnt <= 5'h00;
            else if (tad_tick)
                conv_cnt <= conv_cnt + 5'h01;
            if (!module_on_bit) begin
                op_cnt             <= 4'h0;
                use_b              <= 1'b0;
                buffer_fill_status <= 1'b0;
            end else if (conv_fin) begin
                op_cnt <= op_wrap ? 4'h0 : op_cnt + 4'h1;
                use_b  <= alternate_input_mode & ~use_b;
                if (op_wrap)
                    buffer_fill_status <= buffer_fill_mode & ~buffer_fill_status;
            end
        end
    end

    // Sample enable and done flags; hardware set wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_enable_bit <= 1'b0;
            conv_done         <= 1'b0;
        end else begin
            sample_enable_bit <= (next_state == sasc_pkg::SASC_SAMPLE);
            if (conv_fin)
                conv_done <= 1'b1;
            else if (end_sample_enable_bit)
                conv_done <= 1'b0;
            else if (wr1 && !pwdata[`SASC_C1_DONE])
                conv_done <= 1'b0;
        end
    end

    // ----------------------------------------
    // Analog side outputs
    // ----------------------------------------
    wire [3:0] chan_mask = channel_count_sel[1] ? 4'hF :
                           channel_count_sel[0] ? 4'h3 : 4'h1;
    wire [1:0] vref_sel  = reference_config[2] ? 2'h0 : reference_config[1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctl       <= '0;
            dma_increment    <= 1'b0;
            dma_buffer_words <= 8'h01;
        end else begin
            analog_ctl.sampling     <= (next_state == sasc_pkg::SASC_SAMPLE);
            analog_ctl.channels     <= chan_mask;
            analog_ctl.simultaneous <= simultaneous_sample_sel & (|channel_count_sel);
            analog_ctl.use_b        <= use_b;
            analog_ctl.scan         <= scan_enable_bit & ~use_b;
            analog_ctl.vref_sel     <= vref_sel;
            analog_ctl.start_conv   <= end_sample_enable_bit;
            dma_increment           <= op_wrap;
            dma_buffer_words        <= 8'h01 << buffer_depth_sel;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_sim_zero_12b: assert property (@(posedge pclk) disable iff (!presetn)
        resolution_mode_sel |-> !rd1[`SASC_C1_SIM]) else $error("sim bit not zero");
    a_chn_zero_12b: assert property (@(posedge pclk) disable iff (!presetn)
        resolution_mode_sel |-> rd2[9:8] == 2'h0) else $error("chps not zero");
    a_done_on_fin: assert property (@(posedge pclk) disable iff (!presetn)
        conv_fin |=> conv_done) else $error("done not set");
    a_done_clr_start: assert property (@(posedge pclk) disable iff (!presetn)
        end_sample_enable_bit |=> !conv_done) else $error("done not cleared");
    a_sample_enable_bit_tracks: assert property (@(posedge pclk) disable iff (!presetn)
        sample_enable_bit == analog_ctl.sampling) else $error("sample_enable_bit mismatch");
    a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
        conv_fin && auto_sample_start && module_on_bit |=> sample_enable_bit)
        else $error("no auto restart");
    a_inc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        op_wrap |=> dma_increment ##1 !dma_increment) else $error("dma pulse");
    a_off_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !module_on_bit |=> op_cnt == 4'h0 && !buffer_fill_status)
        else $error("off not reset");
    a_buffer_fill_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !buffer_fill_mode && $rose(op_wrap) |=> !buffer_fill_status)
        else $error("buffer_fill_status set w/o buffer_fill_mode");
    a_div_cap: assert property (@(posedge pclk) disable iff (!presetn)
        tad_cnt <= 8'h40) else $error("divider overrun");

    // ----------------------------------------
    // Sequencing and output checks
    // ----------------------------------------
    // Outputs are registered, so each check except a_rc_period looks one cycle after its cause
    a_sim_off_single: assert property (@(posedge pclk) disable iff (!presetn)
        !simultaneous_sample_sel |=> !analog_ctl.simultaneous)
        else $error("simultaneous without select");
    a_one_chan_12b: assert property (@(posedge pclk) disable iff (!presetn)
        resolution_mode_sel |=> analog_ctl.channels == 4'h1)
        else $error("more than one channel in 12-bit");
    a_vref_default: assert property (@(posedge pclk) disable iff (!presetn)
        reference_config[2] |=> analog_ctl.vref_sel == 2'h0)
        else $error("reference not supply");
    a_sw_start_sample_enable_bit: assert property (@(posedge pclk) disable iff (!presetn)
        sw_set && module_on_bit && state == sasc_pkg::SASC_IDLE |=> analog_ctl.sampling)
        else $error("software start ignored");
    a_end_starts: assert property (@(posedge pclk) disable iff (!presetn)
        end_sample_enable_bit |=> analog_ctl.start_conv && !analog_ctl.sampling)
        else $error("conversion not started");
    a_scan_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        use_b |=> !analog_ctl.scan)
        else $error("scan during sample B");
    a_alt_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !alternate_input_mode && conv_fin |=> !use_b)
        else $error("sample B without alternate");
    a_rc_period: assert property (@(posedge pclk) disable iff (!presetn)
        conv_clock_source && $past(conv_clock_source) |-> tad_cnt <= 8'(`SASC_RC_CYC - 1))
        else $error("divider used with RC clock");
    a_auto_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
        state == sasc_pkg::SASC_SAMPLE && auto_trig && module_on_bit && !tad_tick
        |=> state == sasc_pkg::SASC_SAMPLE)
        else $error("auto end off a period boundary");
    a_depth_words: assert property (@(posedge pclk) disable iff (!presetn)
        dma_buffer_words == (8'h01 << $past(buffer_depth_sel)))
        else $error("buffer words wrong");
    a_done_no_set: assert property (@(posedge pclk) disable iff (!presetn)
        !conv_done && !conv_fin && wr1 && pwdata[`SASC_C1_DONE] |=> !conv_done)
        else $error("software set done");
    a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !module_on_bit |=> state == sasc_pkg::SASC_IDLE)
        else $error("sequencer runs while off");
    a_buffer_fill_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
        module_on_bit && !op_wrap |=> $stable(buffer_fill_status))
        else $error("fill status moved between increments");
endmodule : sasc_ctrl

// *** bench/sasc_core_model.sv ***
// Behavioural sample/hold and converter core facing the controller
`timescale 1ns/10ps

module sasc_core_model (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  sasc_pkg::sasc_analog_t analog_ctl,
    input  wire logic              dma_increment,
    input  wire logic              fire,
    output logic                   ext_trigger,
    output logic [7:0]             sample_len,
    output logic [7:0]             conv_at_inc
);
    logic [7:0] run_len;
    logic [7:0] conv_run;
    logic [2:0] trig_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_len     <= 8'h00;
            conv_run    <= 8'h00;
            trig_cnt    <= 3'h0;
            sample_len  <= 8'h00;
            conv_at_inc <= 8'h00;
        end else begin
            // Held four cycles so the three-stage synchroniser cannot miss it
            if (fire) begin
                trig_cnt <= 3'h4;
            end else if (trig_cnt != 3'h0) begin
                trig_cnt <= trig_cnt - 3'h1;
            end
            // Amplifiers track only while sampling; length of each run kept
            if (analog_ctl.sampling) begin
                run_len <= run_len + 8'h01;
            end else begin
                if (run_len != 8'h00) begin
                    sample_len <= run_len;
                end
                run_len <= 8'h00;
            end
            // Conversions started between two DMA increments
            if (dma_increment) begin
                conv_at_inc <= conv_run;
                conv_run    <= 8'h00;
            end else if (analog_ctl.start_conv) begin
                conv_run <= conv_run + 8'h01;
            end
        end
    end

    assign ext_trigger = (trig_cnt != 3'h0);
endmodule : sasc_core_model

// *** bench/tb.sv ***
// Self-checking testbench for the sequence controller
`timescale 1ns/10ps
`include "sasc_regs.svh"

module tb;
    // --------------------------------
    // Signals
    // --------------------------------
    logic                   pclk    = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel    = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite  = 1'b0;
    logic                   fire    = 1'b0;
    logic [11:0]            paddr   = 12'h000;
    logic [31:0]            pwdata  = 32'h0000_0000;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   ext_trigger;
    logic                   dma_increment;
    sasc_pkg::sasc_analog_t ctl;
    logic [7:0]             words;
    logic [7:0]             sample_len;
    logic [7:0]             conv_at_inc;
    logic [31:0]            exp_q[$];
    logic [31:0]            rdat;
    logic                   err;
    logic [15:0]            v;
    int                     fails        = 0;
    int                     total_checks = 0;

    always #25 pclk = ~pclk;

    sasc_ctrl #(.CONV_TAD(2)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_trigger(ext_trigger),
        .analog_ctl(ctl), .dma_increment(dma_increment), .dma_buffer_words(words)
    );

    sasc_core_model i_core (
        .pclk(pclk), .presetn(presetn), .analog_ctl(ctl), .dma_increment(dma_increment),
        .fire(fire), .ext_trigger(ext_trigger), .sample_len(sample_len),
        .conv_at_inc(conv_at_inc)
    );

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, rdat, err);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        apb(1'b0, a, 32'h0000_0000, rdat, err);
    endtask : rd

    // Bounded waits: a missing event shows up as a later mismatch
    task automatic wait_start();
        for (int n = 0; n < 200 && ctl.start_conv !== 1'b1; n++) @(posedge pclk);
    endtask : wait_start

    task automatic wait_done();
        rdat = 32'h0000_0000;
        for (int n = 0; n < 100 && rdat[0] !== 1'b1; n++) begin
            apb(1'b0, `SASC_OFF_CTRL1, 32'h0000_0000, rdat, err);
        end
    endtask : wait_done

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Read data compared at the completing edge against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check(prdata, exp_q.pop_front());
        end
    end

    initial begin
        #(20000 * 50);
        fails++;
        $display("watchdog expired");
        end_of_test();
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        void'($urandom(76056));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SASC_OFF_CTRL1, 16'h0000);
        rd(`SASC_OFF_CTRL2, 16'h0000);
        rd(`SASC_OFF_CLKT, 16'h0000);
        rd(`SASC_OFF_DEPTH, 16'h0000);
        rd(12'h010, 16'h0000);
        check({31'h0, err}, 32'h0000_0001);
        check({24'h00, words}, 32'h0000_0001);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom());
            wr(`SASC_OFF_CLKT, v);
            rd(`SASC_OFF_CLKT, v & `SASC_C3_WMASK);
            wr(`SASC_OFF_DEPTH, {v[15:3], i[2:0]});
            rd(`SASC_OFF_DEPTH, {13'h0000, i[2:0]});
            check({24'h00, words}, 32'h0000_0001 << i);
            wr(`SASC_OFF_CTRL2, {i[2:0], v[12:0]});
            rd(`SASC_OFF_CTRL2, {i[2:0], v[12:0]} & `SASC_C2_WMASK & 16'hFF7F);
            check({30'h0, ctl.vref_sel}, i[2] ? 32'h0 : {30'h0, i[1:0]});
        end
        $display("register test done");
        wr(`SASC_OFF_CTRL1, 16'h0408);
        rd(`SASC_OFF_CTRL1, 16'h0400);
        wr(`SASC_OFF_CTRL2, 16'h0300);
        rd(`SASC_OFF_CTRL2, 16'h0000);
        wr(`SASC_OFF_CTRL1, 16'h0000);
        $display("resolution test done");
        // Manual start, four channels together, software ends sampling
        wr(`SASC_OFF_CLKT, 16'h0000);
        wr(`SASC_OFF_CTRL2, 16'h0300);
        // Module must be on before a sample-enable write is honoured
        wr(`SASC_OFF_CTRL1, 16'h8008);
        wr(`SASC_OFF_CTRL1, 16'h800A);
        check({31'h0, ctl.sampling}, 32'h0000_0001);
        check({28'h0, ctl.channels}, 32'h0000_000F);
        check({31'h0, ctl.simultaneous}, 32'h0000_0001);
        rd(`SASC_OFF_CTRL1, 16'h800A);
        wr(`SASC_OFF_CTRL1, 16'h8008);
        wait_start();
        @(posedge pclk);
        check({31'h0, ctl.sampling}, 32'h0000_0000);
        wait_done();
        rd(`SASC_OFF_CTRL1, 16'h8009);
        wr(`SASC_OFF_CTRL1, 16'h8008);
        rd(`SASC_OFF_CTRL1, 16'h8008);
        wr(`SASC_OFF_CTRL1, 16'h8009);
        rd(`SASC_OFF_CTRL1, 16'h8008);
        $display("manual test done");
        // External trigger, split buffer and alternating inputs
        wr(`SASC_OFF_CTRL2, 16'h0003);
        for (int k = 0; k < 2; k++) begin
            wr(`SASC_OFF_CTRL1, 16'h8022);
            check({31'h0, ctl.use_b}, k);
            check({28'h0, ctl.channels}, 32'h0000_0001);
            fire <= 1'b1;
            @(posedge pclk);
            fire <= 1'b0;
            wait_start();
            wait_done();
            rd(`SASC_OFF_CTRL2, (k == 0) ? 16'h0083 : 16'h0003);
        end
        $display("trigger test done");
        // Automatic sampling and internal counter, increment every third
        wr(`SASC_OFF_CTRL1, 16'h0000);
        wr(`SASC_OFF_CTRL2, 16'h0008);
        wr(`SASC_OFF_CLKT, 16'h0301);
        wr(`SASC_OFF_CTRL1, 16'h80E4);
        repeat (2) begin
            for (int n = 0; n < 500 && dma_increment !== 1'b1; n++) @(posedge pclk);
            @(posedge pclk);
        end
        check({24'h00, conv_at_inc}, 32'h0000_0003);
        check({31'h0, sample_len inside {8'h06, 8'h07}}, 32'h0000_0001);
        wr(`SASC_OFF_CTRL1, 16'h0000);
        $display("auto test done");
        end_of_test();
    end
endmodule : tb
